// ---- rtl/lbp_pkg.sv ----
// Purpose: Shared constants for the local bus pin interface
// Assumes: 200 MHz core clock
// Notes:   Timing counts in core clock cycles
package lbp_pkg;
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned ALE_WIDTH_NS   = 10;
  localparam int unsigned ALE_CYCLES     =
    (ALE_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned STROBE_MIN_NS  = 20;
  localparam int unsigned STROBE_CYCLES  =
    (STROBE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ADDR_W         = 16;
  localparam int unsigned DATA_W         = 16;
  localparam logic [7:0]  CNT_RST        = 8'h00;

  typedef enum logic [5:0] {
    LBP_ST_IDLE   = 6'h01,
    LBP_ST_ALE    = 6'h02,
    LBP_ST_STROBE = 6'h04,
    LBP_ST_WAIT   = 6'h08,
    LBP_ST_HREQ   = 6'h10,
    LBP_ST_HOLD   = 6'h20
  } lbp_state_t;
endpackage

// ---- rtl/lbp_sync.sv ----
// Purpose: Two flip-flop synchroniser for a vector of pin inputs
// Assumes: Inputs asynchronous to core_clk_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module lbp_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic        RST_V = 1'b0
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= {WIDTH{RST_V}};
      sync_r <= {WIDTH{RST_V}};
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end
  assign sync_o = sync_r;
endmodule
`default_nettype wire

// ---- rtl/lbp_top.sv ----
// Purpose: Local bus pin interface, device side
// Assumes: Control pins sampled through two flops, data lines sampled directly; tristate resolved outside
// Notes:   Master cycles start on req_valid_i; hold has priority
`timescale 1ns/1ps
`default_nettype none
// Function
// - Sixteen-bit address bus driven on bidirectional local address lines.
// - Sixteen-bit bidirectional local data bus for transfers.
// - Split bus mode puts address bits 15:0 on the address lines.
// - Split bus mode puts address bits 31:16 on the data lines.
// - Hold request high means device drives bus; low asks for hold.
// - In hold, drive bus request low to regain bus, high once regained.
// - Hold status pin as output goes low to confirm hold.
// - Hold status input high keeps device in hold, bus released.
// - Assert peripheral select to pick the addressed peripheral.
// - Accessed party holds ready low to extend the bus cycle.
// - Two peripheral interrupts; decode style sets their inactive level.
// - Interrupt output toward the local microcontroller.
module lbp_top (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        split_bus_select_i,
  input  wire logic [31:0] split_addr_i,
  input  wire logic        req_valid_i,
  input  wire logic        req_write_i,
  input  wire logic        req_wide_i,
  input  wire logic [15:0] req_addr_i,
  input  wire logic [15:0] req_wdata_i,
  input  wire logic        req_want_bus_i,
  output logic             req_ready_o,
  output logic             rsp_valid_o,
  output logic [15:0]      rsp_rdata_o,
  input  wire logic        decode_style_select_i,
  output logic             local_cpu_irq_o,
  input  wire logic        local_cpu_irq_req_i,
  output logic             periph_irq_o,
  output logic [15:0]      local_addr_lines_o,
  output logic             local_addr_lines_oe_o,
  input  wire logic [15:0] local_data_lines_i,
  output logic [15:0]      local_data_lines_o,
  output logic             local_data_lines_oe_o,
  input  wire logic        hold_request_in_i,
  output logic             bus_request_out_o,
  input  wire logic        hold_status_pin_i,
  output logic             hold_status_pin_o,
  output logic             hold_status_pin_oe_o,
  input  wire logic        hold_status_as_input_i,
  output logic             peripheral_select_out_o,
  input  wire logic        slave_select_in_i,
  output logic             slave_selected_o,
  output logic             address_latch_strobe_o,
  output logic             read_strobe_o,
  output logic             write_strobe_o,
  output logic             upper_byte_enable_o,
  output logic             strobe_oe_o,
  input  wire logic        cycle_extend_ready_i,
  output logic             cycle_extend_ready_o,
  output logic             cycle_extend_ready_oe_o,
  input  wire logic        peripheral_irq_one_i,
  input  wire logic        peripheral_irq_two_i
);
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] ALE_N = 8'(lbp_pkg::ALE_CYCLES);
  localparam logic [7:0] STB_N = 8'(lbp_pkg::STROBE_CYCLES);

  initial begin
    if (lbp_pkg::ALE_CYCLES < 1 || lbp_pkg::ALE_CYCLES > 255 ||
        lbp_pkg::STROBE_CYCLES < 1 || lbp_pkg::STROBE_CYCLES > 255)
      $error("Timing counts out of range");
  end

  // Pin synchronisers: hold, hold status, ready, slave select, irqs
  logic [5:0] pins_s;
  lbp_sync #(.WIDTH(6), .RST_V(1'b1)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    ({hold_request_in_i, hold_status_pin_i, cycle_extend_ready_i,
                  slave_select_in_i, peripheral_irq_one_i,
                  peripheral_irq_two_i}),
    .sync_o     (pins_s)
  );
  logic hreq_s, hstat_s, rdy_s, csi_s, irq1_s, irq2_s;
  assign {hreq_s, hstat_s, rdy_s, csi_s, irq1_s, irq2_s} = pins_s;

  // Inactive level follows decode style
  function automatic logic irq_active(input logic pin, input logic style);
    irq_active = style ? ~pin : pin;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    lbp_pkg::lbp_state_t st;
    logic [7:0]          cnt;
    logic [15:0]         addr;
    logic [15:0]         wdata;
    logic                wr;
    logic                wide;
    logic [15:0]         rdata;
    logic                rsp;
    logic                ale;
    logic                rd;
    logic                wrs;
    logic                bhe;
    logic                cso;
    logic                breq;
    logic                irqo;
    logic                pirq;
    logic                ssel;
  } lbp_regs_t;

  lbp_regs_t q_r;
  lbp_regs_t q_nxt;

  logic hold_want;
  assign hold_want = !hreq_s || (hold_status_as_input_i && hstat_s);

  always_comb begin
    q_nxt      = q_r;
    q_nxt.rsp  = 1'b0;
    q_nxt.irqo = local_cpu_irq_req_i;
    q_nxt.pirq = irq_active(irq1_s, decode_style_select_i) |
                 irq_active(irq2_s, decode_style_select_i);
    q_nxt.ssel = !csi_s;
    case (q_r.st)
      lbp_pkg::LBP_ST_IDLE: begin
        if (hold_want) begin
          q_nxt.st = lbp_pkg::LBP_ST_HOLD;
        end else if (req_valid_i) begin
          q_nxt.st    = lbp_pkg::LBP_ST_ALE;
          q_nxt.addr  = req_addr_i;
          q_nxt.wdata = req_wdata_i;
          q_nxt.wr    = req_write_i;
          q_nxt.wide  = req_wide_i;
          q_nxt.ale   = 1'b1;
          q_nxt.cso   = 1'b0;
          q_nxt.cnt   = ALE_N;
        end
      end
      lbp_pkg::LBP_ST_ALE: begin
        if (q_r.cnt <= 8'h01) begin
          q_nxt.ale = 1'b0;
          q_nxt.st  = lbp_pkg::LBP_ST_STROBE;
          q_nxt.rd  = q_r.wr;
          q_nxt.wrs = !q_r.wr;
          q_nxt.bhe = !q_r.wide;
          q_nxt.cnt = STB_N;
        end else begin
          q_nxt.cnt = q_r.cnt - 8'h01;
        end
      end
      lbp_pkg::LBP_ST_STROBE: begin
        if (q_r.cnt <= 8'h01) begin
          q_nxt.st = lbp_pkg::LBP_ST_WAIT;
        end else begin
          q_nxt.cnt = q_r.cnt - 8'h01;
        end
      end
      lbp_pkg::LBP_ST_WAIT: begin
        if (rdy_s) begin
          q_nxt.rdata = local_data_lines_i;
          q_nxt.rsp   = 1'b1;
          q_nxt.rd    = 1'b1;
          q_nxt.wrs   = 1'b1;
          q_nxt.bhe   = 1'b1;
          q_nxt.cso   = 1'b1;
          q_nxt.st    = lbp_pkg::LBP_ST_IDLE;
        end
      end
      lbp_pkg::LBP_ST_HOLD: begin
        if (!hold_want && req_want_bus_i) begin
          q_nxt.breq = 1'b0;
          q_nxt.st   = lbp_pkg::LBP_ST_HREQ;
        end else if (!hold_want) begin
          q_nxt.st = lbp_pkg::LBP_ST_IDLE;
        end
      end
      lbp_pkg::LBP_ST_HREQ: begin
        if (!hold_want) begin
          q_nxt.breq = 1'b1;
          q_nxt.st   = lbp_pkg::LBP_ST_IDLE;
        end
      end
      default: q_nxt.st = lbp_pkg::LBP_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r       <= '0;
      q_r.st    <= lbp_pkg::LBP_ST_IDLE;
      q_r.cnt   <= lbp_pkg::CNT_RST;
      q_r.rd    <= 1'b1;
      q_r.wrs   <= 1'b1;
      q_r.bhe   <= 1'b1;
      q_r.cso   <= 1'b1;
      q_r.breq  <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic in_hold;
  logic driving;
  assign in_hold = (q_r.st == lbp_pkg::LBP_ST_HOLD) ||
                   (q_r.st == lbp_pkg::LBP_ST_HREQ);
  assign driving = !in_hold;

  // Split mode carries the wide address on both pin groups
  assign local_addr_lines_o = split_bus_select_i ? split_addr_i[15:0]
                                                 : q_r.addr;
  assign local_data_lines_o = split_bus_select_i ? split_addr_i[31:16]
                                                 : q_r.wdata;
  assign local_addr_lines_oe_o = driving;
  // Data pins driven for writes and in split mode, never in hold; reads leave them to the peripheral
  assign local_data_lines_oe_o = driving &&
    (split_bus_select_i || (q_r.wr && q_r.st != lbp_pkg::LBP_ST_IDLE));
  assign strobe_oe_o           = driving;
  assign hold_status_pin_o     = !in_hold;
  assign hold_status_pin_oe_o  = !hold_status_as_input_i;
  assign bus_request_out_o     = q_r.breq;
  assign peripheral_select_out_o = q_r.cso;
  assign address_latch_strobe_o  = q_r.ale;
  assign read_strobe_o           = q_r.rd;
  assign write_strobe_o          = q_r.wrs;
  assign upper_byte_enable_o     = q_r.bhe;
  // Device always ready when addressed as slave; no wait states added
  assign cycle_extend_ready_o    = 1'b1;
  assign cycle_extend_ready_oe_o = q_r.ssel;
  assign slave_selected_o        = q_r.ssel;
  assign local_cpu_irq_o         = q_r.irqo;
  assign periph_irq_o            = q_r.pirq;
  assign req_ready_o  = (q_r.st == lbp_pkg::LBP_ST_IDLE) && !hold_want;
  assign rsp_valid_o  = q_r.rsp;
  assign rsp_rdata_o  = q_r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Latch strobe stands two cycles, then exactly one strobe goes low
  sequence s_ale_then_strobe;
    address_latch_strobe_o [*2] ##1
      (!address_latch_strobe_o && (!read_strobe_o ^ !write_strobe_o));
  endsequence

  a_ale_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(address_latch_strobe_o) |-> s_ale_then_strobe)
    else $error("Latch strobe width wrong");
  a_hold_release: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    in_hold |-> !local_addr_lines_oe_o && !strobe_oe_o)
    else $error("Bus driven in hold");
  a_hold_confirm: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    in_hold |-> !hold_status_pin_o)
    else $error("Hold not confirmed");
  a_hold_enter: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ($past(q_r.st) == lbp_pkg::LBP_ST_IDLE && !$past(hreq_s))
      |-> q_r.st == lbp_pkg::LBP_ST_HOLD)
    else $error("Hold request ignored");
  a_stay_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (in_hold && hold_status_as_input_i && hstat_s) |=> in_hold)
    else $error("Left hold while held");
  a_breq_low: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !bus_request_out_o |-> q_r.st == lbp_pkg::LBP_ST_HREQ)
    else $error("Bus request outside hold");
  a_ale_first: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(address_latch_strobe_o) |-> (!read_strobe_o ^ !write_strobe_o))
    else $error("Strobe not after latch");
  a_split_addr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    split_bus_select_i |-> local_data_lines_o == split_addr_i[31:16] &&
      local_addr_lines_o == split_addr_i[15:0])
    else $error("Split address wrong");
  a_cso_cycle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    address_latch_strobe_o |-> !peripheral_select_out_o)
    else $error("Select missing in cycle");
  a_wait_ready: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (q_r.st == lbp_pkg::LBP_ST_WAIT && !rdy_s) |=> !rsp_valid_o)
    else $error("Ended without ready");
endmodule
`default_nettype wire

// ---- sim/lbp_periph.sv ----
// Purpose: Local peripheral on the far side of the local bus
// Assumes: Strobes and select active low, ready pulled up
// Notes:   Read data is address xor 16'hA5C3
`timescale 1ns/1ps
`default_nettype none
module lbp_periph (
  input  wire logic        clk_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        cs_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [3:0]  wait_i,
  output logic      [15:0] data_o,
  output logic             rdy_o
);
  logic        act;
  logic [3:0]  cnt;
  logic [15:0] last;
  logic        strb;
  assign strb = !cs_n_i && (!rd_n_i || !wr_n_i);
  // Ready low while counting wait states
  assign rdy_o = !strb || (act && cnt == 4'h0);
  // Released bus shows inverse of last value, not a stale copy
  assign data_o = (strb && !rd_n_i) ? (addr_i ^ 16'hA5C3) : ~last;
  always @(posedge clk_i) begin
    if (strb) begin
      if (!act) begin
        act <= 1'b1;
        cnt <= wait_i;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
      if (!rd_n_i) last <= addr_i ^ 16'hA5C3;
    end else begin
      act <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the local bus pin interface
// Assumes: Far side modelled by lbp_periph
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic        w;
    logic        b;
    logic [15:0] a;
    logic [15:0] d;
  } lbp_exp_t;
  logic core_clk_i = 0, rst_n_i = 0, split = 0, valid = 0, wr = 0, wide = 0;
  logic want = 0, hreq = 1, hs_in = 0, hs_tb = 1, ss_n = 1, cirq = 0;
  logic style = 0, irq1 = 0, irq2 = 0, ale_q = 0, seen = 0;
  logic [31:0] saddr = 32'h0000_0000;
  logic [15:0] addr = 16'h0000, wd = 16'h0000, dl_o, dl_i, al, pd;
  logic [3:0]  wst = 4'h0;
  logic ready, rsp, cirq_o, pirq, al_oe, dl_oe, breq, hs_o, hs_oe, cso;
  logic ssel, ale, rd_n, wr_n, bhe_n, s_oe, rdy_o, rdy_oe, prdy;
  logic [15:0] rdata;
  int error_cnt = 0, comparisons = 0, cyc = 0, n, seed = 73257;
  lbp_exp_t q[$];
  lbp_exp_t e;
  wire logic rdy_w = rdy_oe ? rdy_o : prdy;
  wire logic hs_w = hs_oe ? hs_o : hs_tb;
  assign dl_i = dl_oe ? dl_o : pd;
  lbp_top i_lbp_top (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .split_bus_select_i(split), .split_addr_i(saddr), .req_valid_i(valid),
    .req_write_i(wr), .req_wide_i(wide), .req_addr_i(addr),
    .req_wdata_i(wd), .req_want_bus_i(want), .req_ready_o(ready),
    .rsp_valid_o(rsp), .rsp_rdata_o(rdata), .decode_style_select_i(style),
    .local_cpu_irq_o(cirq_o), .local_cpu_irq_req_i(cirq),
    .periph_irq_o(pirq), .local_addr_lines_o(al),
    .local_addr_lines_oe_o(al_oe), .local_data_lines_i(dl_i),
    .local_data_lines_o(dl_o), .local_data_lines_oe_o(dl_oe),
    .hold_request_in_i(hreq), .bus_request_out_o(breq),
    .hold_status_pin_i(hs_w), .hold_status_pin_o(hs_o),
    .hold_status_pin_oe_o(hs_oe), .hold_status_as_input_i(hs_in),
    .peripheral_select_out_o(cso), .slave_select_in_i(ss_n),
    .slave_selected_o(ssel), .address_latch_strobe_o(ale),
    .read_strobe_o(rd_n), .write_strobe_o(wr_n),
    .upper_byte_enable_o(bhe_n), .strobe_oe_o(s_oe),
    .cycle_extend_ready_i(rdy_w), .cycle_extend_ready_o(rdy_o),
    .cycle_extend_ready_oe_o(rdy_oe), .peripheral_irq_one_i(irq1),
    .peripheral_irq_two_i(irq2));
  lbp_periph i_lbp_periph (.clk_i(core_clk_i), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .cs_n_i(cso), .addr_i(al), .wait_i(wst), .data_o(pd), .rdy_o(prdy));
  ////////////////////////////////////////////////////////////////////////////
  initial forever #2.5 core_clk_i = ~core_clk_i;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic clk(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask
  task automatic req();
    for (n = 0; n < 200 && ready !== 1'b1; n++) clk(1);
    wr = $random(seed);
    wide = $random(seed);
    addr = $random(seed);
    wd = $random(seed);
    wst = $random(seed);
    q.push_back('{wr, !wide, addr, wd});
    valid = 1;
    clk(1);
    valid = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scoreboard: address at latch strobe, strobes, write data, read data
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  always @(posedge core_clk_i) begin
    if (ale && !ale_q && q.size() > 0) begin
      chk(al, q[0].a);
      chk(16'(al_oe), 16'h0001);
    end
    if (!ale && !ale_q && (!rd_n || !wr_n) && !seen && q.size() > 0) begin
      seen = 1;
      chk(16'(cso), 16'h0000);
      chk(16'({rd_n, wr_n, bhe_n}), 16'({q[0].w, !q[0].w, q[0].b}));
      chk(16'(dl_oe), 16'(q[0].w));
      if (q[0].w) chk(dl_o, q[0].d);
    end
    if (rsp) begin
      e = q.pop_front();
      seen = 0;
      if (!e.w) chk(rdata, e.a ^ 16'hA5C3);
    end
    ale_q = ale;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk(4);
    rst_n_i = 1;
    repeat (40) req();
    clk(40);
    chk(16'(q.size()), 16'h0000);
    split = 1;
    saddr = $random(seed);
    clk(3);
    chk(al, saddr[15:0]);
    chk(dl_o, saddr[31:16]);
    split = 0;
    for (int h = 0; h < 2; h++) begin
      hs_in = h[0];
      hs_tb = h[0];
      hreq = 0;
      for (n = 0; n < 20 && al_oe !== 1'b0; n++) clk(1);
      chk(16'({al_oe, dl_oe, s_oe, ready}), 16'h0000);
      if (h == 0) chk(16'({hs_oe, hs_o}), 16'h0002);
      hreq = 1;
      want = 1;
      if (h == 1) begin
        clk(10);
        chk(16'({al_oe, breq}), 16'h0001);
        hs_tb = 0;
      end
      for (n = 0; n < 20 && breq !== 1'b0; n++) clk(1);
      chk(16'(breq), 16'h0000);
      for (n = 0; n < 20 && ready !== 1'b1; n++) clk(1);
      chk(16'({breq, al_oe}), 16'h0003);
      want = 0;
    end
    req();
    clk(40);
    for (int s = 0; s < 2; s++) begin
      style = s[0];
      {irq1, irq2} = {2{style}};
      clk(6);
      chk(16'(pirq), 16'h0000);
      irq1 = !style;
      clk(6);
      chk(16'(pirq), 16'h0001);
      {irq1, irq2} = {style, !style};
      clk(6);
      chk(16'(pirq), 16'h0001);
    end
    cirq = 1;
    clk(2);
    chk(16'(cirq_o), 16'h0001);
    cirq = 0;
    clk(2);
    chk(16'(cirq_o), 16'h0000);
    ss_n = 0;
    clk(5);
    chk(16'({ssel, rdy_oe, rdy_w}), 16'h0007);
    ss_n = 1;
    clk(5);
    chk(16'(rdy_oe), 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
